// [qlm_pkg.sv]
// Package with mode encodings and timing constants for the quad LIN mode controller
package qlm_pkg;
  localparam int NCH = 4;
  // Device modes, one-hot
  typedef enum logic [4:0] {
    QLM_OFF = 5'h01,
    QLM_LP = 5'h02,
    QLM_NORM = 5'h04,
    QLM_UV = 5'h08,
    QLM_OT = 5'h10
  } qlm_mode_t;
  // Channel sub-modes, one-hot
  typedef enum logic [3:0] {
    QLM_CH_SLEEP = 4'h1,
    QLM_CH_INIT = 4'h2,
    QLM_CH_NORM = 4'h4,
    QLM_CH_FAST = 4'h8
  } qlm_ch_t;
  localparam int CLK_MHZ = 250;
  // Channel initialization period in ns (default figure, no printed value)
  localparam int CH_INIT_NS = 100;
  localparam int CH_INIT_CYC = (CH_INIT_NS * CLK_MHZ + 999) / 1000;
  // Filter delay on the io supply undervoltage detector, ns
  localparam int UV_FILT_NS = 40;
  localparam int UV_FILT_CYC = (UV_FILT_NS * CLK_MHZ + 999) / 1000;
  // Idle timeout for the startup interrupt, us
  localparam int IDLE_TO_US = 1000;
  localparam int IDLE_TO_CYC = IDLE_TO_US * CLK_MHZ;
  localparam logic [4:0] MODE_RST = 5'h01;
endpackage

// [qlm_sync_if.sv]
// Interface carrying synchronised detector levels between modules
`timescale 1ns/1ps
interface qlm_sync_if;
  logic [3:0] raw;
  logic [3:0] synced;
  modport src (input raw, output synced);
  modport dst (input synced, output raw);
endinterface

// [qlm_sync.sv]
// Two-flop synchroniser bank for the analog detector indications
`timescale 1ns/1ps
module qlm_sync #(
  parameter int W = 4
) (
  input wire logic clk, // Device clock
  input wire logic resetn, // Async reset, active low
  qlm_sync_if.src sif // Raw and synced levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  // Second flop is the only reader of the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= sif.raw;
      sync_r <= meta_r;
    end
  end
  assign sif.synced = sync_r;
endmodule

// [qlm_chan.sv]
// One LIN channel sub-mode machine
`timescale 1ns/1ps
module qlm_chan #(
  parameter int INIT_CYC = qlm_pkg::CH_INIT_CYC
) (
  input wire logic clk, // Device clock
  input wire logic resetn, // Async reset, active low
  input wire logic run, // Channel controller enabled
  input wire logic sleep_bit, // Sleep request bit
  input wire logic init_bit, // Initialization request bit
  input wire logic fast_bit, // channel_fast_baud_bit
  input wire logic busy, // Frame in progress
  output qlm_pkg::qlm_ch_t sub, // Current sub-mode
  output logic ready, // Frames may be accepted
  output logic abort // Abort pulse on entering init
);
  logic [15:0] cnt_r;
  qlm_pkg::qlm_ch_t nxt;
  // Sub-mode selection; sleep waits for the frame to end
  always_comb begin
    nxt = sub;
    if (sleep_bit) begin
      if (!busy) nxt = qlm_pkg::QLM_CH_SLEEP;
    end else if (init_bit) begin
      nxt = qlm_pkg::QLM_CH_INIT;
    end else if (fast_bit) begin
      nxt = qlm_pkg::QLM_CH_FAST;
    end else begin
      nxt = qlm_pkg::QLM_CH_NORM;
    end
  end
  // State register, held in reset while the controller is off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub <= qlm_pkg::QLM_CH_INIT;
      abort <= 1'b0;
    end else if (!run) begin
      sub <= qlm_pkg::QLM_CH_INIT;
      abort <= 1'b0;
    end else begin
      sub <= nxt;
      abort <= (nxt == qlm_pkg::QLM_CH_INIT) && (sub != qlm_pkg::QLM_CH_INIT);
    end
  end
  // Short settle before frames are accepted in normal or fast
  // Judged on the next sub-mode, so ready drops on the edge the channel leaves
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      ready <= 1'b0;
    end else if (!run || !(nxt == qlm_pkg::QLM_CH_NORM || nxt == qlm_pkg::QLM_CH_FAST)) begin
      cnt_r <= '0;
      ready <= 1'b0;
    end else if (cnt_r < 16'(INIT_CYC)) begin
      cnt_r <= cnt_r + 16'h0001;
      ready <= 1'b0;
    end else begin
      ready <= 1'b1;
    end
  end
  ch_ready_a: assert property (@(posedge clk) disable iff (!resetn)
    ready |-> (sub == qlm_pkg::QLM_CH_NORM || sub == qlm_pkg::QLM_CH_FAST))
    else $error("channel ready outside normal");
  ch_abort_a: assert property (@(posedge clk) disable iff (!resetn)
    abort |-> sub == qlm_pkg::QLM_CH_INIT)
    else $error("abort without init sub-mode");
endmodule

// [qlm_top.sv]
// Device mode controller for the four-channel LIN bridge
`timescale 1ns/1ps
module qlm_top #(
  parameter int NCH = qlm_pkg::NCH,
  parameter int IDLE_CYC = qlm_pkg::IDLE_TO_CYC,
  parameter int UV_CYC = qlm_pkg::UV_FILT_CYC
) (
  input wire logic clk, // Device clock 250 MHz
  input wire logic resetn, // Async power-on reset, active low
  input wire logic battery_supply_sense, // Battery above power-on threshold
  input wire logic battery_off_det, // Battery below power-off threshold
  input wire logic io_supply_sense, // io supply undervoltage detected
  input wire logic ot_det, // Junction above shutdown threshold
  input wire logic low_power_request_bit, // Host low-power request
  input wire logic [NCH-1:0] sleep_bits, // Per-channel sleep bit
  input wire logic [NCH-1:0] init_bits, // Per-channel init bit
  input wire logic [NCH-1:0] channel_fast_baud_bit, // channel_config_reg_one fast bits
  input wire logic [NCH-1:0] frame_busy, // Per-channel frame in progress
  input wire logic [NCH-1:0] tx_request, // Per-channel transmit request
  input wire logic irq_pending, // Other enabled interrupt pending
  input wire logic startup_clear, // Host clears startup interrupt
  input wire logic pll_locked, // PLL lock indication
  input wire logic [NCH-1:0] lin_wake, // Remote LIN wake per channel
  input wire logic spi_wake, // SPI wake request
  output qlm_pkg::qlm_mode_t mode, // Current device mode
  output logic [4*NCH-1:0] ch_sub, // Per-channel one-hot sub-modes
  output logic [NCH-1:0] tx_start, // Frame start granted
  output logic [NCH-1:0] tx_abort, // Abort frame pulse
  output logic [NCH-1:0] bus_drv_en, // LIN driver enable
  output logic [NCH-1:0] pullup_en, // Master pull-up enable
  output logic [NCH-1:0] wake_watch, // Remote wake detection on
  output logic pll_en, // PLL enable
  output logic regs_rst, // Register file reset hold
  output logic spi_access_en, // SPI register access allowed
  output logic startup_interrupt_flag, // Startup interrupt status
  output logic irq_out_n, // Interrupt output, active low
  output logic regulator_inhibit_out_n, // Inhibit pin level
  output logic regulator_inhibit_oe, // Inhibit pin drive enable
  output logic stat_out, // Availability pin level
  output logic stat_oe // Availability pin drive enable
);
  qlm_sync_if sif();
  logic bat_on, bat_off, uv, ot;
  logic [31:0] idle_cnt_r;
  logic [15:0] uv_cnt_r;
  logic all_sleep, any_busy, run;
  logic [NCH-1:0] ready, abort_ch;
  qlm_pkg::qlm_ch_t sub_w [NCH];
  qlm_pkg::qlm_mode_t mode_nxt;

  // Detector levels cross into the clock domain first
  assign sif.raw = {ot_det, io_supply_sense, battery_off_det, battery_supply_sense};
  qlm_sync #(.W(4)) qlm_sync_inst (
    .clk(clk),
    .resetn(resetn),
    .sif(sif)
  );
  assign bat_on = sif.synced[0];
  assign bat_off = sif.synced[1];
  assign uv = sif.synced[2];
  assign ot = sif.synced[3];

  assign all_sleep = &sleep_bits;
  assign any_busy = |frame_busy;
  assign run = (mode == qlm_pkg::QLM_NORM);

  // Independent channel machines
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    qlm_chan qlm_chan_inst (
      .clk(clk),
      .resetn(resetn),
      .run(run),
      .sleep_bit(sleep_bits[i]),
      .init_bit(init_bits[i]),
      .fast_bit(channel_fast_baud_bit[i]),
      .busy(frame_busy[i]),
      .sub(sub_w[i]),
      .ready(ready[i]),
      .abort(abort_ch[i])
    );
  end

  // Filter on io undervoltage so glitches do not drop the mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      uv_cnt_r <= '0;
    end else if (!uv || mode != qlm_pkg::QLM_NORM) begin
      uv_cnt_r <= '0;
    end else if (uv_cnt_r <= 16'(UV_CYC)) begin
      uv_cnt_r <= uv_cnt_r + 16'h0001;
    end
  end

  // Startup idle timer runs while the flag is set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_r <= '0;
    end else if (mode != qlm_pkg::QLM_NORM || !startup_interrupt_flag) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r < 32'(IDLE_CYC)) begin
      idle_cnt_r <= idle_cnt_r + 32'h00000001;
    end
  end

  // Device mode transitions; power-off wins over all else
  always_comb begin
    mode_nxt = mode;
    if (bat_off) begin
      mode_nxt = qlm_pkg::QLM_OFF;
    end else begin
      unique case (mode)
        qlm_pkg::QLM_OFF: if (bat_on) mode_nxt = qlm_pkg::QLM_NORM;
        qlm_pkg::QLM_LP: if ((|lin_wake) || spi_wake) mode_nxt = qlm_pkg::QLM_NORM;
        qlm_pkg::QLM_NORM: begin
          if (ot) begin
            mode_nxt = qlm_pkg::QLM_OT;
          end else if (uv_cnt_r > 16'(UV_CYC)) begin
            mode_nxt = qlm_pkg::QLM_UV;
          end else if (startup_interrupt_flag && idle_cnt_r >= 32'(IDLE_CYC)) begin
            mode_nxt = qlm_pkg::QLM_LP;
          end else if (low_power_request_bit && all_sleep && !any_busy && !irq_pending
                       && !startup_interrupt_flag) begin
            mode_nxt = qlm_pkg::QLM_LP;
          end
        end
        qlm_pkg::QLM_UV: begin
          if (ot) mode_nxt = qlm_pkg::QLM_OT;
          else if (!uv) mode_nxt = qlm_pkg::QLM_NORM;
        end
        qlm_pkg::QLM_OT: if (!ot) mode_nxt = qlm_pkg::QLM_OFF;
        default: mode_nxt = qlm_pkg::QLM_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode <= qlm_pkg::qlm_mode_t'(qlm_pkg::MODE_RST);
    end else begin
      mode <= mode_nxt;
    end
  end

  // Startup flag: set on entry to Normal except from UV, set beats clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startup_interrupt_flag <= 1'b0;
    end else if (mode_nxt == qlm_pkg::QLM_NORM && mode != qlm_pkg::QLM_NORM
                 && mode != qlm_pkg::QLM_UV) begin
      startup_interrupt_flag <= 1'b1;
    end else if (mode_nxt != qlm_pkg::QLM_NORM) begin
      startup_interrupt_flag <= 1'b0;
    end else if (startup_clear) begin
      startup_interrupt_flag <= 1'b0;
    end
  end

  // Per-mode output levels, all registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regs_rst <= 1'b1;
      spi_access_en <= 1'b0;
      pll_en <= 1'b0;
      irq_out_n <= 1'b1;
      regulator_inhibit_out_n <= 1'b0;
      regulator_inhibit_oe <= 1'b0;
      stat_out <= 1'b0;
      stat_oe <= 1'b0;
    end else begin
      regs_rst <= mode_nxt != qlm_pkg::QLM_NORM || (mode != qlm_pkg::QLM_NORM
                  && mode != qlm_pkg::QLM_UV);
      spi_access_en <= mode_nxt == qlm_pkg::QLM_NORM;
      pll_en <= mode_nxt == qlm_pkg::QLM_NORM;
      irq_out_n <= !((startup_interrupt_flag || irq_pending) && mode == qlm_pkg::QLM_NORM);
      regulator_inhibit_out_n <= 1'b0;
      // Inhibit pulled low in Normal only; floats in Low Power and Off
      regulator_inhibit_oe <= mode_nxt == qlm_pkg::QLM_NORM;
      stat_out <= 1'b0;
      stat_oe <= mode_nxt == qlm_pkg::QLM_LP || mode_nxt == qlm_pkg::QLM_UV
                 || mode_nxt == qlm_pkg::QLM_OT;
    end
  end

  // Channel-facing outputs; drivers only while Normal
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch_sub <= '0;
      tx_start <= '0;
      tx_abort <= '0;
      bus_drv_en <= '0;
      pullup_en <= '0;
      wake_watch <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ch_sub[4*i +: 4] <= sub_w[i];
        tx_start[i] <= run && tx_request[i] && ready[i] && pll_locked;
        tx_abort[i] <= abort_ch[i] || (frame_busy[i] && mode_nxt == qlm_pkg::QLM_OT);
        bus_drv_en[i] <= run && mode_nxt == qlm_pkg::QLM_NORM
                         && sub_w[i] != qlm_pkg::QLM_CH_INIT;
        pullup_en[i] <= mode_nxt == qlm_pkg::QLM_NORM || mode_nxt == qlm_pkg::QLM_LP
                        || mode_nxt == qlm_pkg::QLM_UV;
        wake_watch[i] <= mode_nxt == qlm_pkg::QLM_LP || (run && sub_w[i] == qlm_pkg::QLM_CH_SLEEP);
      end
    end
  end

  // Mode transition checks
  off_exit_a: assert property (@(posedge clk) disable iff (!resetn)
    bat_off |=> mode == qlm_pkg::QLM_OFF)
    else $error("power-off not honoured");
  ot_rel_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_OT && !ot && !bat_off) |=> mode == qlm_pkg::QLM_OFF)
    else $error("overtemp release missed");
  lp_entry_a: assert property (@(posedge clk) disable iff (!resetn)
    ($past(mode) == qlm_pkg::QLM_NORM && mode == qlm_pkg::QLM_LP) |->
    ($past(low_power_request_bit) && $past(all_sleep) && !$past(any_busy)
     && !$past(irq_pending)) || $past(startup_interrupt_flag))
    else $error("bad low power entry");
  init_set_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_OFF && bat_on && !bat_off) |=> startup_interrupt_flag ##1 !irq_out_n)
    else $error("startup flag not set");
  norm_entry_a: assert property (@(posedge clk) disable iff (!resetn)
    ((mode != qlm_pkg::QLM_NORM && mode != qlm_pkg::QLM_UV) ##1 (mode == qlm_pkg::QLM_NORM))
    |-> (startup_interrupt_flag && regs_rst))
    else $error("entry to normal without defaults");
  idle_to_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_NORM && startup_interrupt_flag && idle_cnt_r >= 32'(IDLE_CYC)
     && !bat_off && !ot && uv_cnt_r <= 16'(UV_CYC)) |=> mode == qlm_pkg::QLM_LP)
    else $error("startup timeout missed");
  tx_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    (|tx_start) |-> $past(pll_locked) && $past(run))
    else $error("tx without lock");
  tx_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode != qlm_pkg::QLM_NORM) |=> tx_start == '0)
    else $error("frame start outside normal");
  wake_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_LP && spi_wake && !bat_off) |=> mode == qlm_pkg::QLM_NORM)
    else $error("wake ignored");
  // Per-mode output checks; outputs and mode load on the same edge
  stat_a: assert property (@(posedge clk) disable iff (!resetn)
    stat_oe == (mode == qlm_pkg::QLM_LP || mode == qlm_pkg::QLM_UV || mode == qlm_pkg::QLM_OT))
    else $error("status pin wrong");
  lp_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_LP) |-> !pll_en && !spi_access_en && !regulator_inhibit_oe)
    else $error("low power leaves blocks on");
  lp_regs_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_LP) |-> regs_rst && wake_watch == '1)
    else $error("low power registers or wake watch wrong");
  norm_spi_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_NORM) |-> spi_access_en && regulator_inhibit_oe && pll_en)
    else $error("normal mode leaves access off");
  off_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_OFF) |-> bus_drv_en == '0 && regs_rst)
    else $error("off mode drives outputs");
  off_drv_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_OFF) |-> pullup_en == '0 && !pll_en && !spi_access_en)
    else $error("off mode leaves blocks on");
  uv_mode_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_UV) |-> bus_drv_en == '0 && !spi_access_en)
    else $error("undervoltage mode drives bus");
  ot_mode_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_OT) |-> bus_drv_en == '0 && pullup_en == '0 && !pll_en)
    else $error("overtemp leaves drivers on");
  ot_abort_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_NORM && ot && !bat_off && (|frame_busy)) |=> tx_abort != '0)
    else $error("overtemp did not abort frame");
  flag_norm_a: assert property (@(posedge clk) disable iff (!resetn)
    (mode != qlm_pkg::QLM_NORM) |-> !startup_interrupt_flag)
    else $error("startup flag outside normal");
  // Recessive bus while a channel initialises
  for (genvar i = 0; i < NCH; i++) begin : g_chk
    init_recess_a: assert property (@(posedge clk) disable iff (!resetn)
      (ch_sub[4*i +: 4] == qlm_pkg::QLM_CH_INIT) |-> !bus_drv_en[i])
      else $error("bus driven during channel init");
  end
  // Main scenarios
  cv_lp_c: cover property (@(posedge clk) disable iff (!resetn) mode == qlm_pkg::QLM_LP);
  cv_ot_c: cover property (@(posedge clk) disable iff (!resetn) mode == qlm_pkg::QLM_OT);
  cv_uv_c: cover property (@(posedge clk) disable iff (!resetn) mode == qlm_pkg::QLM_UV);
  cv_tx_c: cover property (@(posedge clk) disable iff (!resetn) |tx_start);
  cv_wake_c: cover property (@(posedge clk) disable iff (!resetn)
    (mode == qlm_pkg::QLM_LP) ##1 (mode == qlm_pkg::QLM_NORM));
endmodule

// [qlm_host_model.sv]
// Host microcontroller model that answers the startup interrupt
`timescale 1ns/1ps
module qlm_host_model #(
  parameter int DELAY = 6
) (
  input wire logic clk, // Device clock
  input wire logic resetn, // Async reset, active low
  input wire logic irq_out_n, // Interrupt pin from the device
  input wire logic startup_interrupt_flag, // Startup status as read back
  input wire logic stall, // Bench asks the host to stay silent
  output logic startup_clear // One-cycle clear pulse
);
  logic [7:0] wait_r;
  // Clear the startup flag some cycles after the interrupt pin falls
  // A stalled host never clears, so the device idle timeout can expire
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 8'h00;
      startup_clear <= 1'b0;
    end else begin
      startup_clear <= 1'b0;
      if (!irq_out_n && startup_interrupt_flag && !stall && !startup_clear) begin
        wait_r <= wait_r + 8'h01;
        if (wait_r == DELAY[7:0]) begin
          startup_clear <= 1'b1;
          wait_r <= 8'h00;
        end
      end else begin
        wait_r <= 8'h00;
      end
    end
  end
endmodule

// [qlm_top_bench.sv]
// Self-checking bench for the quad LIN mode controller
`timescale 1ns/1ps
module qlm_top_bench;
  logic clk, resetn, bat_on, bat_off, uv, ot, lp_req, irq_pend, pll, spi_wk, stall, clr;
  logic [3:0] slp, ini, fast, busy, txr, lwk;
  qlm_pkg::qlm_mode_t mode;
  logic [15:0] ch_sub;
  logic [3:0] tx_start, tx_abort, drv_en, pu_en, wake_watch;
  logic pll_en, regs_rst, spi_en, flag, irq_n, inh_oe, stat_oe, inh_n, stat_pin;
  int fails, comparisons, cycles;
  qlm_top #(.IDLE_CYC(50), .UV_CYC(10)) qlm_top_inst (.clk(clk), .resetn(resetn),
    .battery_supply_sense(bat_on), .battery_off_det(bat_off), .io_supply_sense(uv),
    .ot_det(ot), .low_power_request_bit(lp_req), .sleep_bits(slp), .init_bits(ini),
    .channel_fast_baud_bit(fast), .frame_busy(busy), .tx_request(txr),
    .irq_pending(irq_pend), .startup_clear(clr), .pll_locked(pll), .lin_wake(lwk),
    .spi_wake(spi_wk), .mode(mode), .ch_sub(ch_sub), .tx_start(tx_start), .tx_abort(tx_abort),
    .bus_drv_en(drv_en), .pullup_en(pu_en), .wake_watch(wake_watch), .pll_en(pll_en),
    .regs_rst(regs_rst), .spi_access_en(spi_en), .startup_interrupt_flag(flag),
    .irq_out_n(irq_n), .regulator_inhibit_out_n(inh_n), .regulator_inhibit_oe(inh_oe),
    .stat_out(stat_pin), .stat_oe(stat_oe));
  qlm_host_model qlm_host_model_inst (.clk(clk), .resetn(resetn), .irq_out_n(irq_n),
    .startup_interrupt_flag(flag), .stall(stall), .startup_clear(clr));
  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_mode(qlm_pkg::qlm_mode_t got, qlm_pkg::qlm_mode_t exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t mode got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t bits got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a mode, then judge it
  task automatic wait_mode(qlm_pkg::qlm_mode_t e, int n);
    for (int i = 0; i < n && mode !== e; i++) begin
      settle(1);
    end
    chk_mode(mode, e);
  endtask
  task automatic t_power_up();
    @(posedge clk) bat_on <= 1'b1;
    wait_mode(qlm_pkg::QLM_NORM, 10);
    settle(1);
    chk_bits({14'h0000, irq_n, flag}, 16'h0001);
    chk_bits({12'h000, spi_en, inh_oe, stat_oe, pll_en}, 16'h000D);
    chk_bits({14'h0000, inh_n, stat_pin}, 16'h0000);
    settle(20);
    chk_bits({15'h0000, flag}, 16'h0000);
    $display("power-up test done");
  endtask
  task automatic t_channels();
    chk_bits(ch_sub, 16'h4444);
    @(posedge clk) ini <= 4'h4;
    settle(2);
    chk_bits({12'h000, tx_abort}, 16'h0004);
    settle(2);
    chk_bits(ch_sub, 16'h4244);
    chk_bits({15'h0000, drv_en[2]}, 16'h0000);
    @(posedge clk) fast <= 4'h2;
    settle(4);
    chk_bits(ch_sub, 16'h4284);
    @(posedge clk) begin
      ini <= 4'h0;
      fast <= 4'h0;
      pll <= 1'b1;
      txr <= 4'hF;
    end
    settle(40);
    chk_bits({12'h000, tx_start}, 16'h000F);
    @(posedge clk) pll <= 1'b0;
    settle(3);
    chk_bits({12'h000, tx_start}, 16'h0000);
    @(posedge clk) txr <= 4'h0;
    $display("channel test done");
  endtask
  task automatic t_low_power();
    @(posedge clk) begin
      slp <= 4'hF;
      busy <= 4'h1;
      lp_req <= 1'b1;
    end
    settle(20);
    chk_mode(mode, qlm_pkg::QLM_NORM);
    chk_bits({4'h0, ch_sub[15:4]}, 16'h0111);
    chk_bits({12'h000, wake_watch}, 16'h000E);
    @(posedge clk) begin
      busy <= 4'h0;
      irq_pend <= 1'b1;
    end
    settle(5);
    chk_mode(mode, qlm_pkg::QLM_NORM);
    @(posedge clk) irq_pend <= 1'b0;
    wait_mode(qlm_pkg::QLM_LP, 10);
    @(posedge clk) lp_req <= 1'b0;
    settle(2);
    chk_bits({11'h000, pll_en, spi_en, inh_oe, stat_oe, regs_rst}, 16'h0003);
    chk_bits({12'h000, wake_watch}, 16'h000F);
    $display("low power test done");
  endtask
  task automatic t_wake();
    @(posedge clk) begin
      stall <= 1'b1;
      lwk <= 4'h8;
    end
    @(posedge clk) lwk <= 4'h0;
    wait_mode(qlm_pkg::QLM_NORM, 10);
    wait_mode(qlm_pkg::QLM_LP, 80);
    @(posedge clk) begin
      stall <= 1'b0;
      spi_wk <= 1'b1;
    end
    @(posedge clk) spi_wk <= 1'b0;
    wait_mode(qlm_pkg::QLM_NORM, 10);
    settle(1);
    chk_bits({15'h0000, flag}, 16'h0001);
    @(posedge clk) slp <= 4'h0;
    settle(20);
    $display("wake test done");
  endtask
  task automatic t_faults();
    @(posedge clk) uv <= 1'b1;
    settle(5);
    chk_mode(mode, qlm_pkg::QLM_NORM);
    wait_mode(qlm_pkg::QLM_UV, 20);
    settle(2);
    chk_bits({11'h000, stat_oe, drv_en}, 16'h0010);
    @(posedge clk) uv <= 1'b0;
    wait_mode(qlm_pkg::QLM_NORM, 10);
    @(posedge clk) begin
      ot <= 1'b1;
      busy <= 4'h1;
    end
    wait_mode(qlm_pkg::QLM_OT, 10);
    chk_bits({12'h000, tx_abort}, 16'h0001);
    settle(2);
    chk_bits({7'h00, pll_en, drv_en, pu_en}, 16'h0000);
    @(posedge clk) begin
      bat_on <= 1'b0;
      ot <= 1'b0;
      busy <= 4'h0;
    end
    wait_mode(qlm_pkg::QLM_OFF, 10);
    settle(2);
    chk_bits({11'h000, regs_rst, drv_en}, 16'h0010);
    @(posedge clk) bat_on <= 1'b1;
    wait_mode(qlm_pkg::QLM_NORM, 10);
    settle(20);
    @(posedge clk) begin
      bat_on <= 1'b0;
      bat_off <= 1'b1;
    end
    wait_mode(qlm_pkg::QLM_OFF, 10);
    $display("fault test done");
  endtask
  // Main sequence: all inputs quiet, reset for five cycles, then tests
  initial begin
    {resetn, bat_on, bat_off, uv, ot, lp_req, irq_pend, pll, spi_wk, stall} = 10'h000;
    {slp, ini, fast, busy, txr, lwk} = 24'h000000;
    fails = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    settle(2);
    t_power_up();
    t_channels();
    t_low_power();
    t_wake();
    t_faults();
    stop_test();
  end
endmodule
